// ### rtl/fgcw_pkg.sv
// Purpose: Shared constants and types for the filter and gain control word block
// Assumes: 100 MHz system clock
// Notes:   Field positions are bit numbers of the 15-bit word, bit 1 at index 0
package fgcw_pkg;

  // ----------------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------------
  localparam int          FGCW_WORD_W     = 15;
  localparam int          FGCW_FILT_LSB   = 9;   // Word bits 15..10
  localparam int          FGCW_FILT_W     = 6;
  localparam int          FGCW_PWR_POS    = 8;   // Word bit 9
  localparam int          FGCW_G1_LSB     = 6;   // Word bits 8..7
  localparam int          FGCW_G2_LSB     = 4;   // Word bits 6..5
  localparam int          FGCW_G3_LSB     = 2;   // Word bits 4..3
  localparam int          FGCW_POST_POS   = 1;   // Word bit 2
  localparam int          FGCW_OFS_POS    = 0;   // Word bit 1
  localparam logic [14:0] FGCW_WORD_RESET = 15'h0000;
  localparam logic [5:0]  FGCW_BYPASS_CODE = 6'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int FGCW_CLK_PERIOD_NS  = 10;
  localparam int FGCW_PK_RST_MIN_NS  = 25;
  // Least time rounds up
  localparam int FGCW_PK_RST_CYCLES  =
    (FGCW_PK_RST_MIN_NS + FGCW_CLK_PERIOD_NS - 1) / FGCW_CLK_PERIOD_NS;
  // Shared pin turnaround: synchroniser depth plus the pad flops, with a spare
  localparam int FGCW_TURN_CYCLES    = 6;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {FGCW_ST_IDLE, FGCW_ST_CMD, FGCW_ST_WR, FGCW_ST_RD} fgcw_state_t;

  typedef struct packed {
    logic [5:0] corner_mhz;      // Filter corner in MHz
    logic       filter_on;
    logic       filter_high_pwr;
    logic       amp_high_pwr;
    logic [4:0] input_amp_db;    // 9, 12 or 15
    logic [4:0] second_amp_db;
    logic [4:0] third_amp_db;
    logic [3:0] post_amp_db;     // 3 or 9
    logic       offset_loop_en;
  } fgcw_settings_t;

endpackage : fgcw_pkg

// ### rtl/fgcw_ctrl.sv
// Purpose: Serial-loaded control word and its decode for a dual-channel filter/amp
// Assumes: Serial pins are asynchronous to clk_i and much slower (160 ns clock)
// Notes:   One decoded settings bundle drives both channels
//          The shared pin input is ignored until read data has drained away
//
// How it works
// - one 15-bit word, fixed field layout
// - filter code is unsigned MHz, MSB first
// - zero code bypasses and powers down filter
// - nonzero code equals corner frequency
// - power bit low: amps low power
// - power bit high, filter: filter high power
// - power bit high, bypass: amps high power
// - input gain 15, 12, 9, 9 dB
// - post gain 3 dB or 9 dB
// - same settings for both channels
// - enable pin low disables whole device; peak hold discharge still follows the pin
// - coupling pin low enables input bias
// - 25 ns high pulse resets peak hold
// - bit 1 set disables offset loop
// - stage 2/3 gains 21, 18, 15, 12 dB
// - write: LE low, leading 1, 15 bits LSB first
// - read: leading 0, 15 bits out on falling edges
`timescale 1ns/100ps
module fgcw_ctrl
  import fgcw_pkg::*;
#(
  parameter int WORD_W = FGCW_WORD_W
) (
  // System
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  // Serial port pins
  input  wire logic           latch_enable_pin_i,
  input  wire logic           serial_clk_i,
  input  wire logic           serial_data_i,
  input  wire logic           serial_out_peak_reset_pin_i,
  output logic                serial_out_peak_reset_pin_o,
  output logic                serial_out_peak_reset_pin_oe_o,
  // Device pins
  input  wire logic           chip_enable_pin_i,
  input  wire logic           input_common_mode_couple_select_i,
  // Analog control outputs
  output fgcw_settings_t      settings_o,
  output logic                device_enable_o,
  output logic                input_bias_en_o,
  output logic                peak_hold_discharge_o,
  output logic [WORD_W-1:0]   control_word_o
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] le_sync_reg;
  logic [2:0] sck_sync_reg;
  logic [2:0] sdi_sync_reg;
  logic [2:0] rstp_sync_reg;
  logic [2:0] en_sync_reg;
  logic [2:0] cpl_sync_reg;
  logic       le_reg;
  logic       sck_reg;
  logic       sdi_reg;
  logic       rstp_reg;
  logic       en_reg;
  logic       cpl_reg;

  // Stage 1 feeds only stage 2; a change counts when stages 2 and 3 agree
  function automatic logic filt(input logic [2:0] s, input logic held);
    filt = (s[1] == s[2]) ? s[2] : held;
  endfunction : filt

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Idle levels, so no unknown and no false edge follows reset
      le_sync_reg   <= 3'h7;
      sck_sync_reg  <= 3'h0;
      sdi_sync_reg  <= 3'h0;
      rstp_sync_reg <= 3'h0;
      en_sync_reg   <= 3'h0;
      cpl_sync_reg  <= 3'h7;
    end else begin
      le_sync_reg   <= {le_sync_reg[1:0], latch_enable_pin_i};
      sck_sync_reg  <= {sck_sync_reg[1:0], serial_clk_i};
      sdi_sync_reg  <= {sdi_sync_reg[1:0], serial_data_i};
      rstp_sync_reg <= {rstp_sync_reg[1:0], serial_out_peak_reset_pin_i};
      en_sync_reg   <= {en_sync_reg[1:0], chip_enable_pin_i};
      cpl_sync_reg  <= {cpl_sync_reg[1:0], input_common_mode_couple_select_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      le_reg   <= 1'b1;
      sck_reg  <= 1'b0;
      sdi_reg  <= 1'b0;
      rstp_reg <= 1'b0;
      en_reg   <= 1'b0;
      cpl_reg  <= 1'b1;
    end else begin
      le_reg   <= filt(le_sync_reg, le_reg);
      sck_reg  <= filt(sck_sync_reg, sck_reg);
      sdi_reg  <= filt(sdi_sync_reg, sdi_reg);
      rstp_reg <= filt(rstp_sync_reg, rstp_reg);
      en_reg   <= filt(en_sync_reg, en_reg);
      cpl_reg  <= filt(cpl_sync_reg, cpl_reg);
    end
  end

  wire le_next_v  = filt(le_sync_reg, le_reg);
  wire sck_next_v = filt(sck_sync_reg, sck_reg);
  wire sck_rise   = sck_next_v & ~sck_reg;
  wire sck_fall   = ~sck_next_v & sck_reg;
  wire le_rise    = le_next_v & ~le_reg;
  // Data is stable around the rising edge; the filtered copy matches it
  wire sdi_v      = filt(sdi_sync_reg, sdi_reg);

  // ----------------------------------------------------------------------
  // Serial protocol
  // ----------------------------------------------------------------------
  fgcw_state_t       state_reg, state_next;
  logic [WORD_W-1:0] word_reg, word_next;
  logic [WORD_W-1:0] shift_reg, shift_next;
  logic [4:0]        cnt_reg, cnt_next;
  logic              sdo_reg, sdo_next, sdo_oe_reg, sdo_oe_next;

  wire cnt_full = (cnt_reg == 5'(WORD_W));

  always_comb begin
    state_next  = state_reg;
    word_next   = word_reg;
    shift_next  = shift_reg;
    cnt_next    = cnt_reg;
    sdo_next    = sdo_reg;
    sdo_oe_next = sdo_oe_reg;
    case (state_reg)
      FGCW_ST_IDLE: begin
        if (!le_next_v) begin
          state_next = FGCW_ST_CMD;
          cnt_next   = 5'd0;
        end
      end
      FGCW_ST_CMD: begin
        if (le_rise) begin
          state_next = FGCW_ST_IDLE;
        end else if (sck_rise) begin
          state_next = sdi_v ? FGCW_ST_WR : FGCW_ST_RD;
          shift_next = word_reg;
        end
      end
      FGCW_ST_WR: begin
        if (le_rise) begin
          // Only a full write is applied; partial ones are dropped
          if (cnt_full) begin
            word_next = shift_reg;
          end
          state_next = FGCW_ST_IDLE;
        end else if (sck_rise && !cnt_full) begin
          shift_next = {sdi_v, shift_reg[WORD_W-1:1]};
          cnt_next   = cnt_reg + 5'd1;
        end
      end
      FGCW_ST_RD: begin
        if (le_rise) begin
          state_next  = FGCW_ST_IDLE;
          sdo_oe_next = 1'b0;
          sdo_next    = 1'b0;
        end else if (sck_fall && !cnt_full) begin
          sdo_oe_next = 1'b1;
          sdo_next    = shift_reg[0];
          shift_next  = {1'b0, shift_reg[WORD_W-1:1]};
          cnt_next    = cnt_reg + 5'd1;
        end
      end
      default: begin
        state_next = FGCW_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= FGCW_ST_IDLE;
      cnt_reg   <= 5'd0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_reg   <= FGCW_WORD_RESET;
      shift_reg  <= '0;
      sdo_reg    <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end else begin
      word_reg   <= word_next;
      shift_reg  <= shift_next;
      sdo_reg    <= sdo_next;
      sdo_oe_reg <= sdo_oe_next;
    end
  end

  // ----------------------------------------------------------------------
  // Peak hold reset pulse
  // ----------------------------------------------------------------------
  // Pin is only an input while the device is not driving a read. Read data
  // still drains through the synchroniser once the driver lets go, so the
  // input stays ignored for a few cycles after the output enable drops.
  logic [FGCW_TURN_CYCLES-1:0] oe_hist_reg;
  wire                         pin_turning = |oe_hist_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe_hist_reg <= '0;
    end else begin
      oe_hist_reg <= {oe_hist_reg[FGCW_TURN_CYCLES-2:0], sdo_oe_reg};
    end
  end

  logic [3:0] pk_cnt_reg;
  wire        pk_rst_in = rstp_reg & ~sdo_oe_reg & ~pin_turning;
  wire        pk_long   = (pk_cnt_reg >= 4'(FGCW_PK_RST_CYCLES));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pk_cnt_reg <= 4'd0;
    end else if (!pk_rst_in) begin
      pk_cnt_reg <= 4'd0;
    end else if (!pk_long) begin
      pk_cnt_reg <= pk_cnt_reg + 4'd1;
    end
  end

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  function automatic logic [4:0] stage_db(input logic [1:0] code);
    stage_db = 5'd21 - 5'(3 * code);
  endfunction : stage_db

  // Codes 10 and 11 both give the lowest input gain
  function automatic logic [4:0] input_db(input logic [1:0] code);
    case (code)
      2'h0:    input_db = 5'h0F;
      2'h1:    input_db = 5'h0C;
      default: input_db = 5'h09;
    endcase
  endfunction : input_db

  wire [5:0] filt_code = word_reg[FGCW_FILT_LSB +: FGCW_FILT_W];
  wire       pwr_bit   = word_reg[FGCW_PWR_POS];
  wire [1:0] g1_code   = word_reg[FGCW_G1_LSB +: 2];
  wire       bypass    = (filt_code == FGCW_BYPASS_CODE);

  fgcw_settings_t dec;
  always_comb begin
    dec.corner_mhz      = filt_code;
    dec.filter_on       = ~bypass;
    dec.filter_high_pwr = ~bypass & pwr_bit;
    dec.amp_high_pwr    = bypass & pwr_bit;
    dec.input_amp_db    = input_db(g1_code);
    dec.second_amp_db   = stage_db(word_reg[FGCW_G2_LSB +: 2]);
    dec.third_amp_db    = stage_db(word_reg[FGCW_G3_LSB +: 2]);
    dec.post_amp_db     = word_reg[FGCW_POST_POS] ? 4'd9 : 4'd3;
    dec.offset_loop_en  = ~word_reg[FGCW_OFS_POS];
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // One bundle serves both channels; disable gates settings and input bias off, not peak discharge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      settings_o      <= '0;
      device_enable_o <= 1'b0;
      input_bias_en_o <= 1'b0;
    end else begin
      settings_o      <= en_reg ? dec : '0;
      device_enable_o <= en_reg;
      input_bias_en_o <= en_reg & ~cpl_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peak_hold_discharge_o <= 1'b0;
      control_word_o        <= FGCW_WORD_RESET;
    end else begin
      peak_hold_discharge_o <= pk_long;
      control_word_o        <= word_reg;
    end
  end

  // Pin driver flops sit last so the pad sees no decode glitches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_out_peak_reset_pin_o    <= 1'b0;
      serial_out_peak_reset_pin_oe_o <= 1'b0;
    end else begin
      serial_out_peak_reset_pin_o    <= sdo_reg;
      serial_out_peak_reset_pin_oe_o <= sdo_oe_reg;
    end
  end

endmodule : fgcw_ctrl

// ### tb/fgcw_ctrl_properties.sv
// Purpose: Port assertions for the control word block
// Assumes: Serial and device pins pass a three flop synchroniser
// Notes:   Decode checks wait one steady cycle to allow a registered decode
`timescale 1ns/100ps
module fgcw_ctrl_properties
  import fgcw_pkg::*;
#(
  parameter int WORD_W = FGCW_WORD_W
) (
  // Inputs of the block
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              latch_enable_pin_i,
  input  wire logic              serial_out_peak_reset_pin_i,
  input  wire logic              chip_enable_pin_i,
  input  wire logic              input_common_mode_couple_select_i,
  // Outputs of the block
  input  wire logic              serial_out_peak_reset_pin_oe_o,
  input  wire fgcw_settings_t    settings_o,
  input  wire logic              device_enable_o,
  input  wire logic              input_bias_en_o,
  input  wire logic              peak_hold_discharge_o,
  input  wire logic [WORD_W-1:0] control_word_o
);
  fgcw_settings_t s;
  logic [14:0]    cw;
  assign s  = settings_o;
  assign cw = control_word_o[14:0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence steady_s;
    device_enable_o && $past(device_enable_o) && $stable(control_word_o);
  endsequence
  corner_code_a: assert property (steady_s |-> s.corner_mhz == cw[14:9] && s.filter_on == |cw[14:9])
    else $error("corner decode wrong");
  power_mode_a: assert property (steady_s |-> s.filter_high_pwr == (|cw[14:9] & cw[8])
    && s.amp_high_pwr == (~|cw[14:9] & cw[8])) else $error("power mode wrong");
  input_gain_a: assert property (steady_s |-> s.input_amp_db == (cw[7:6] == 2'h0 ? 5'h0F
    : cw[7:6] == 2'h1 ? 5'h0C : 5'h09)) else $error("input gain wrong");
  stage_gain_a: assert property (steady_s |-> s.second_amp_db == 5'h15 - 5'h03 * {3'h0, cw[5:4]}
    && s.third_amp_db == 5'h15 - 5'h03 * {3'h0, cw[3:2]}) else $error("stage gain wrong");
  post_gain_a: assert property (steady_s |-> s.post_amp_db == (cw[1] ? 4'h9 : 4'h3))
    else $error("post gain wrong");
  offset_loop_a: assert property (steady_s |-> s.offset_loop_en == !cw[0])
    else $error("offset loop wrong");
  disable_all_a: assert property (!chip_enable_pin_i [*6] |-> !device_enable_o && s == '0)
    else $error("disabled device active");
  word_hold_a: assert property (!latch_enable_pin_i [*8] |=> $stable(control_word_o))
    else $error("word changed inside frame");
  input_bias_a: assert property ((device_enable_o && !input_common_mode_couple_select_i) [*6]
    |-> input_bias_en_o) else $error("bias not on");
  peak_reset_a: assert property ((serial_out_peak_reset_pin_i && !serial_out_peak_reset_pin_oe_o)
    [*8] |=> peak_hold_discharge_o) else $error("peak not discharged");
  cover property (s.filter_high_pwr);
  cover property (s.amp_high_pwr);
  cover property (peak_hold_discharge_o);
endmodule : fgcw_ctrl_properties

// ### tb/fgcw_ser_host_model.sv
// Purpose: Serial host that loads and reads back the control word
// Assumes: Serial clock half period of eight system clocks, still between frames
// Notes:   Data line shows the inverse of its last bit once released
`timescale 1ns/100ps
module fgcw_ser_host_model (
  // System
  input  wire logic clk_i,
  // Serial port and shared pin
  input  wire logic pin_i,
  output logic      le_o,
  output logic      sclk_o,
  output logic      sdata_o,
  output logic      rst_pulse_o
);
  initial begin
    le_o        = 1'h1;
    sclk_o      = 1'h0;
    sdata_o     = 1'h0;
    rst_pulse_o = 1'h0;
  end
  task automatic half;
    repeat (8) @(posedge clk_i);
  endtask : half
  task automatic xfer(input logic wr, input logic [14:0] w, input int n, output logic [14:0] r);
    r = 15'h0000;
    le_o <= 1'h0;
    half();
    sdata_o <= wr;
    half();
    sclk_o <= 1'h1;
    for (int i = 0; i < n; i++) begin
      half();
      sclk_o  <= 1'h0;
      sdata_o <= w[i];
      half();
      sclk_o <= 1'h1;
      r[i] = pin_i;
    end
    half();
    sclk_o <= 1'h0;
    half();
    le_o    <= 1'h1;
    sdata_o <= ~sdata_o;
    half();
  endtask : xfer
  task automatic pulse(input int cyc);
    rst_pulse_o <= 1'h1;
    repeat (cyc) @(posedge clk_i);
    rst_pulse_o <= 1'h0;
  endtask : pulse
endmodule : fgcw_ser_host_model

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the control word block
// Assumes: Host model paces the serial clock from the system clock
// Notes:   Decode expectations are rebuilt here from the field table
`timescale 1ns/100ps
module tb_top;
  import fgcw_pkg::*;
  logic           clk = 1'h0, rst = 1'h1, ce = 1'h1, cpl = 1'h1;
  logic           hrst, le, sclk, sdata, sdo, oe, pin, dev_en, bias, dis;
  logic [14:0]    word, rd;
  fgcw_settings_t set;
  int             bad_count = 0, tests_run = 0;
  int             dis_cycles = 0;
  always #5 clk = ~clk;
  // Counts cycles with the peak hold discharge active
  always @(posedge clk) begin
    if (dis === 1'h1)
      dis_cycles <= dis_cycles + 1;
  end
  // The device wins the shared pin while it drives read data
  assign pin = oe ? sdo : hrst;
  fgcw_ctrl u_dut (.clk_i(clk), .rst_i(rst), .latch_enable_pin_i(le), .serial_clk_i(sclk),
    .serial_data_i(sdata), .serial_out_peak_reset_pin_i(pin), .serial_out_peak_reset_pin_o(sdo),
    .serial_out_peak_reset_pin_oe_o(oe), .chip_enable_pin_i(ce),
    .input_common_mode_couple_select_i(cpl), .settings_o(set), .device_enable_o(dev_en),
    .input_bias_en_o(bias), .peak_hold_discharge_o(dis), .control_word_o(word));
  fgcw_ser_host_model u_host (.clk_i(clk), .pin_i(pin), .le_o(le), .sclk_o(sclk),
    .sdata_o(sdata), .rst_pulse_o(hrst));
  task automatic chk(input string what, input logic [28:0] exp, input logic [28:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic fgcw_settings_t exp_set(input logic [14:0] w);
    fgcw_settings_t s;
    s.corner_mhz      = w[14:9];
    s.filter_on       = |w[14:9];
    s.filter_high_pwr = s.filter_on & w[8];
    s.amp_high_pwr    = ~s.filter_on & w[8];
    s.input_amp_db    = (w[7:6] == 2'h0) ? 5'h0F : (w[7:6] == 2'h1) ? 5'h0C : 5'h09;
    s.second_amp_db   = 5'h15 - 5'h03 * {3'h0, w[5:4]};
    s.third_amp_db    = 5'h15 - 5'h03 * {3'h0, w[3:2]};
    s.post_amp_db     = w[1] ? 4'h9 : 4'h3;
    s.offset_loop_en  = ~w[0];
    return s;
  endfunction : exp_set
  task automatic t_words;
    logic [14:0] tbl [4] = '{15'h3E0C, 15'h7F5B, 15'h01A5, 15'h00F2};
    int          d0;
    chk("reset settings", exp_set(15'h0000), set);
    for (int i = 0; i < 4; i++) begin
      u_host.xfer(1'h1, tbl[i], 15, rd);
      chk("word", 29'(tbl[i]), 29'(word));
      chk("settings", exp_set(tbl[i]), set);
      d0 = dis_cycles;
      u_host.xfer(1'h0, 15'h0000, 15, rd);
      chk("readback", 29'(tbl[i]), 29'(rd));
      chk("word after read", 29'(tbl[i]), 29'(word));
      chk("read oe", 29'h0, 29'(oe));
      // Read data leaving the shared pin must not look like a peak reset
      repeat (12) @(posedge clk);
      chk("read discharge", 29'(d0), 29'(dis_cycles));
    end
    u_host.xfer(1'h1, 15'h1234, 10, rd);
    chk("short write", 29'h00F2, 29'(word));
  endtask : t_words
  task automatic t_pins;
    ce <= 1'h0;
    repeat (10) @(posedge clk);
    chk("disabled", 29'h0, set);
    chk("enable off", 29'h0, 29'(dev_en));
    ce  <= 1'h1;
    cpl <= 1'h0;
    repeat (10) @(posedge clk);
    chk("enabled", exp_set(15'h00F2), set);
    chk("bias", 29'h1, 29'(bias));
    chk("enable on", 29'h1, 29'(dev_en));
    cpl <= 1'h1;
    repeat (10) @(posedge clk);
    chk("bias off", 29'h0, 29'(bias));
  endtask : t_pins
  task automatic t_peak(input int cyc, input logic exp);
    logic seen;
    seen = 1'h0;
    u_host.pulse(cyc);
    repeat (12) begin
      @(posedge clk);
      seen |= dis;
    end
    chk("discharge", 29'(exp), 29'(seen));
  endtask : t_peak
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    repeat (10) @(posedge clk);
    t_words();
    t_pins();
    t_peak(1, 1'h0);
    t_peak(3, 1'h1);
    t_peak(10, 1'h1);
    test_done();
  end
  // Whole run is near 2600 clocks
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule : tb_top
bind fgcw_ctrl fgcw_ctrl_properties #(.WORD_W(WORD_W)) u_props (.clk_i, .rst_i,
  .latch_enable_pin_i, .serial_out_peak_reset_pin_i, .chip_enable_pin_i,
  .input_common_mode_couple_select_i, .serial_out_peak_reset_pin_oe_o, .settings_o,
  .device_enable_o, .input_bias_en_o, .peak_hold_discharge_o, .control_word_o);
